// ---- atsm_pkg.sv ----
// Constants for the transmit channel slot mapper.
// Assumes a byte-wide control port with register indices as addresses.
package atsm_pkg;
  localparam logic [7:0] ADDR_CH1_CFG = 8'h1e;
  localparam logic [7:0] ADDR_CH2_CFG = 8'h1f;
  localparam logic [7:0] RST_CH1_CFG = 8'h20;
  localparam logic [7:0] RST_CH2_CFG = 8'h21;
  localparam int ENABLE_BIT = 5;
  localparam int SLOT_MSB = 4;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h3f;
  localparam logic [4:0] RIGHT_HALF_BASE = 5'h10;
  localparam int SAMPLE_BITS = 32;
  localparam int BIT_CNT_W = 5;
  localparam int SLOT_CNT_W = 5;
  localparam int CHANNELS = 2;
  localparam logic FMT_TDM = 1'b0;
  localparam logic FMT_I2S_LJ = 1'b1;
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_RUN = 3'b010,
    ST_SYNCED = 3'b100
  } atsm_state_e;
endpackage : atsm_pkg

// ---- atsm_sample_store.sv ----
// Holds the captured channel one sample; the second entry is never written and stays zero.
// Read data comes from a register, one cycle after the address.
`timescale 1ns/10ps
`default_nettype none
module atsm_sample_store
  import atsm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write side
  input wire logic wrEn,
  input wire logic [0:0] wrAddr,
  input wire logic [SAMPLE_BITS-1:0] wrData,
  // Read side
  input wire logic [0:0] rdAddr,
  output logic [SAMPLE_BITS-1:0] rdData
);
  logic [SAMPLE_BITS-1:0] mem_r [CHANNELS];
  logic [SAMPLE_BITS-1:0] rdData_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        mem_r[i] <= '0;
      end
      rdData_r <= '0;
    end
    else
    begin
      if (wrEn)
      begin
        mem_r[wrAddr] <= wrData;
      end
      rdData_r <= mem_r[rdAddr];
    end
  end

  assign rdData = rdData_r;
endmodule // atsm_sample_store
`default_nettype wire

// ---- atsm_tx_slot_map.sv ----
// Transmit channel enable and slot mapper for two serial audio channels.
// Assumes bit clock and frame sync come from outside and are resynchronised
// here; each slot is SAMPLE_BITS bit clocks, MSB first, frame sync high
// marks the first bit of slot 0 (I2S/LJ: left half while frame sync level).
`timescale 1ns/10ps
`default_nettype none
module atsm_tx_slot_map
  import atsm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control port
  input wire logic regWr,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Frame options from neighbouring registers
  input wire logic frameFormat,
  input wire logic unusedCycleFillOption,
  input wire logic [1:0] txChannelPinSelect,
  // Converter samples
  input wire logic sampleValid,
  input wire logic [SAMPLE_BITS-1:0] chOneSample,
  input wire logic [SAMPLE_BITS-1:0] chTwoSample,
  // Link pins
  input wire logic bitClk,
  input wire logic frameSync,
  output logic primaryDataOut,
  output logic primaryDataOe,
  output logic secondaryDataOut,
  output logic secondaryDataOe
);
  logic [7:0] cfg1_r, cfg1_nxt, cfg2_r, cfg2_nxt, regRdData_r, regRdData_nxt;
  logic [2:0] bclkSync_r;
  logic [1:0] fsSync_r;
  logic fsPrev_r, fsPrev_nxt;
  atsm_state_e state_r, state_nxt;
  logic [BIT_CNT_W-1:0] bitCnt_r, bitCnt_nxt;
  logic [SLOT_CNT_W-1:0] slotCnt_r, slotCnt_nxt;
  logic rightHalf_r, rightHalf_nxt;
  logic [SAMPLE_BITS-1:0] shift_r [CHANNELS];
  logic [SAMPLE_BITS-1:0] shift_nxt [CHANNELS];
  logic [CHANNELS-1:0] hit;
  logic pOut_r, pOut_nxt, pOe_r, pOe_nxt, sOut_r, sOut_nxt, sOe_r, sOe_nxt;
  logic bclkRise, bclkFall, fsRise, fsEdge, slotStart;
  logic [SAMPLE_BITS-1:0] storeRd;

  // Registers and read-back
  always_comb
  begin
    cfg1_nxt = cfg1_r;
    cfg2_nxt = cfg2_r;
    regRdData_nxt = 8'h00;
    if (regWr && regAddr == ADDR_CH1_CFG)
    begin
      cfg1_nxt = regWrData & CFG_WRITE_MASK;
    end
    if (regWr && regAddr == ADDR_CH2_CFG)
    begin
      cfg2_nxt = regWrData & CFG_WRITE_MASK;
    end
    if (regAddr == ADDR_CH1_CFG)
    begin
      regRdData_nxt = cfg1_r;
    end
    else if (regAddr == ADDR_CH2_CFG)
    begin
      regRdData_nxt = cfg2_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg1_r <= RST_CH1_CFG;
      cfg2_r <= RST_CH2_CFG;
      regRdData_r <= 8'h00;
    end
    else
    begin
      cfg1_r <= cfg1_nxt;
      cfg2_r <= cfg2_nxt;
      regRdData_r <= regRdData_nxt;
    end
  end

  // Two flops before use; third stage only for edge finding
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bclkSync_r <= 3'h0;
      fsSync_r <= 2'h0;
    end
    else
    begin
      bclkSync_r <= {bclkSync_r[1:0], bitClk};
      fsSync_r <= {fsSync_r[0], frameSync};
    end
  end

  assign bclkRise = bclkSync_r[1] & ~bclkSync_r[2];
  assign bclkFall = ~bclkSync_r[1] & bclkSync_r[2];
  // Frame sync is sampled on bit clock rise, where the host launched it stable
  assign fsRise = bclkRise & fsSync_r[1] & ~fsPrev_r;
  assign fsEdge = bclkRise & (fsSync_r[1] != fsPrev_r);
  assign slotStart = (frameFormat == FMT_TDM) ? fsRise : fsEdge;

  atsm_sample_store u_store (
    .clk(clk),
    .rst(rst),
    .wrEn(sampleValid),
    .wrAddr(1'b0),
    .wrData(chOneSample),
    .rdAddr(1'b0),
    .rdData(storeRd)
  );

  // Slot position tracking
  always_comb
  begin
    state_nxt = state_r;
    fsPrev_nxt = fsPrev_r;
    bitCnt_nxt = bitCnt_r;
    slotCnt_nxt = slotCnt_r;
    rightHalf_nxt = rightHalf_r;
    if (bclkRise)
    begin
      fsPrev_nxt = fsSync_r[1];
      if (slotStart)
      begin
        bitCnt_nxt = '0;
        slotCnt_nxt = '0;
        rightHalf_nxt = (frameFormat == FMT_I2S_LJ) && !fsSync_r[1];
        state_nxt = ST_SYNCED;
      end
      else if (state_r != ST_WAIT)
      begin
        bitCnt_nxt = bitCnt_r + 1'b1;
        if (bitCnt_r == BIT_CNT_W'(SAMPLE_BITS - 1))
        begin
          slotCnt_nxt = slotCnt_r + 1'b1;
        end
        state_nxt = ST_RUN;
      end
    end
    case (state_r)
      ST_WAIT, ST_RUN, ST_SYNCED: ;
      default: state_nxt = ST_WAIT;
    endcase
  end

  // Which channel owns the current slot
  for (genvar c = 0; c < CHANNELS; c++)
  begin : g_hit
    logic [7:0] cfg;
    logic [4:0] slotNum;
    logic [SLOT_CNT_W-1:0] target;
    assign cfg = (c == 0) ? cfg1_r : cfg2_r;
    assign slotNum = cfg[SLOT_MSB:0];
    assign target = (frameFormat == FMT_TDM) ? slotNum :
                    (slotNum >= RIGHT_HALF_BASE) ? slotNum - RIGHT_HALF_BASE : slotNum;
    assign hit[c] = (state_r != ST_WAIT) && cfg[ENABLE_BIT] && (target == slotCnt_r) &&
                    ((frameFormat == FMT_TDM) || (slotNum[4] == rightHalf_r));
  end

  // Shift and drive on bit clock fall
  always_comb
  begin
    pOut_nxt = pOut_r;
    pOe_nxt = pOe_r;
    sOut_nxt = sOut_r;
    sOe_nxt = sOe_r;
    for (int i = 0; i < CHANNELS; i++)
    begin
      shift_nxt[i] = shift_r[i];
    end
    if (bclkRise && slotStart)
    begin
      shift_nxt[0] = chOneSample;
      shift_nxt[1] = chTwoSample;
    end
    if (bclkFall)
    begin
      pOut_nxt = 1'b0;
      pOe_nxt = !unusedCycleFillOption;
      sOut_nxt = 1'b0;
      sOe_nxt = !unusedCycleFillOption;
      // disabled channels never hit; channel one applied last wins
      for (int i = CHANNELS - 1; i >= 0; i--)
      begin
        if (hit[i])
        begin
          if (txChannelPinSelect[i])
          begin
            sOut_nxt = shift_r[i][SAMPLE_BITS-1];
            sOe_nxt = 1'b1;
          end
          else
          begin
            pOut_nxt = shift_r[i][SAMPLE_BITS-1];
            pOe_nxt = 1'b1;
          end
          shift_nxt[i] = {shift_r[i][SAMPLE_BITS-2:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= ST_WAIT;
      fsPrev_r <= 1'b0;
      bitCnt_r <= '0;
      slotCnt_r <= '0;
      rightHalf_r <= 1'b0;
      pOut_r <= 1'b0;
      pOe_r <= 1'b0;
      sOut_r <= 1'b0;
      sOe_r <= 1'b0;
      for (int i = 0; i < CHANNELS; i++)
      begin
        shift_r[i] <= '0;
      end
    end
    else
    begin
      state_r <= state_nxt;
      fsPrev_r <= fsPrev_nxt;
      bitCnt_r <= bitCnt_nxt;
      slotCnt_r <= slotCnt_nxt;
      rightHalf_r <= rightHalf_nxt;
      pOut_r <= pOut_nxt;
      pOe_r <= pOe_nxt;
      sOut_r <= sOut_nxt;
      sOe_r <= sOe_nxt;
      for (int i = 0; i < CHANNELS; i++)
      begin
        shift_r[i] <= shift_nxt[i];
      end
    end
  end

  assign regRdData = regRdData_r;
  assign primaryDataOut = pOut_r;
  assign primaryDataOe = pOe_r;
  assign secondaryDataOut = sOut_r;
  assign secondaryDataOe = sOe_r;

  sequence s_fall_unused;
    bclkFall && hit == 2'b00;
  endsequence

  a_reset_ch1: assert property (@(posedge clk) $rose(rst) |=> cfg1_r == 8'h20)
    else $error("ch1 reset value wrong");
  a_reset_ch2: assert property (@(posedge clk) $rose(rst) |=> cfg2_r == 8'h21)
    else $error("ch2 reset value wrong");
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    cfg1_r[7:6] == 2'b00 && cfg2_r[7:6] == 2'b00)
    else $error("reserved bits set");
  a_ch1_disabled: assert property (@(posedge clk) disable iff (rst)
    !cfg1_r[ENABLE_BIT] |-> !hit[0])
    else $error("disabled ch1 drives");
  a_ch2_disabled: assert property (@(posedge clk) disable iff (rst)
    !cfg2_r[ENABLE_BIT] |-> !hit[1])
    else $error("disabled ch2 drives");
  a_fill_option: assert property (@(posedge clk) disable iff (rst)
    s_fall_unused |=> primaryDataOe == !$past(unusedCycleFillOption) && !primaryDataOut)
    else $error("fill wrong");
  a_pin_route: assert property (@(posedge clk) disable iff (rst)
    bclkFall && hit[0] && !txChannelPinSelect[0] |=> primaryDataOe)
    else $error("primary pin not driven");
  a_ch1_priority: assert property (@(posedge clk) disable iff (rst)
    bclkFall && hit == 2'b11 && txChannelPinSelect == 2'b00
    |=> primaryDataOut == $past(shift_r[0][SAMPLE_BITS-1]))
    else $error("ch1 did not win");
  a_tdm_slot: assert property (@(posedge clk) disable iff (rst)
    hit[0] && frameFormat == FMT_TDM |-> slotCnt_r == cfg1_r[SLOT_MSB:0])
    else $error("tdm slot mismatch");
  a_i2s_half: assert property (@(posedge clk) disable iff (rst)
    hit[0] && frameFormat == FMT_I2S_LJ
    |-> rightHalf_r == cfg1_r[4] && slotCnt_r == {1'b0, cfg1_r[3:0]})
    else $error("i2s slot mismatch");
endmodule // atsm_tx_slot_map
`default_nettype wire

// ---- atsm_host_port.sv ----
// Host audio port model: makes bit clock and frame sync, captures slot words.
// Assumes the device changes data after bit clock falls.
`timescale 1ns/10ps
`default_nettype none
module atsm_host_port
  import atsm_pkg::*;
(
  // Device pins
  input wire logic priOut,
  input wire logic priOe,
  input wire logic secOut,
  input wire logic secOe,
  // Link clocking
  output var logic bitClk,
  output var logic frameSync,
  // Captured words: data and drive mask per pin
  output var logic [127:0] slotWord,
  output var int wordCount
);
  logic [31:0] pw, pm, sw, sm;
  initial
  begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    wordCount = 0;
  end
  // Clock stands still between frames; a released pin reads as its previous bit inverted
  task automatic runFrame(input logic fmt, input int n);
    #1;
    for (int r = 0; r <= n * 32; r++)
    begin
      frameSync = fmt ? (r < n * 16) : (r == 0);
      #24 bitClk = 1'b1;
      pw = {pw[30:0], priOe ? priOut : ~pw[0]};
      pm = {pm[30:0], priOe};
      sw = {sw[30:0], secOe ? secOut : ~sw[0]};
      sm = {sm[30:0], secOe};
      if (r > 0 && r % 32 == 0)
      begin
        slotWord = {pw & pm, pm, sw & sm, sm};
        wordCount++;
      end
      #24 bitClk = 1'b0;
    end
  endtask
endmodule // atsm_host_port
`default_nettype wire

// ---- test_atsm_tx_slot_map.sv ----
// Self-checking bench for the transmit slot mapper.
// Assumes the host port model drives the link and reports slot words.
`timescale 1ns/10ps
`default_nettype none
module test_atsm_tx_slot_map
  import atsm_pkg::*;
;
  logic clk, rst = 1'b1, regWr = 1'b0, fmt = 1'b0, fill = 1'b0, sampleValid = 1'b0;
  logic [1:0] sel = 2'b00;
  logic [7:0] regAddr = 8'h0, regWrData = 8'h0, regRdData, cfg1, cfg2;
  logic [31:0] s1 = 32'h0, s2 = 32'h0, r;
  logic priOut, priOe, secOut, secOe, bitClk, frameSync;
  logic [127:0] slotWord;
  logic [127:0] expQ[$];
  int wordCount, badCount = 0, checked = 0, seed = 13;

  atsm_tx_slot_map u_atsm_tx_slot_map (.clk(clk), .rst(rst), .regWr(regWr),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .frameFormat(fmt),
    .unusedCycleFillOption(fill), .txChannelPinSelect(sel), .sampleValid(sampleValid),
    .chOneSample(s1), .chTwoSample(s2), .bitClk(bitClk), .frameSync(frameSync),
    .primaryDataOut(priOut), .primaryDataOe(priOe), .secondaryDataOut(secOut),
    .secondaryDataOe(secOe));
  atsm_host_port u_atsm_host_port (.priOut(priOut), .priOe(priOe), .secOut(secOut),
    .secOe(secOe), .bitClk(bitClk), .frameSync(frameSync), .slotWord(slotWord),
    .wordCount(wordCount));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp)
    begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A word with no note left is always a mismatch
  always @(wordCount)
    chk(slotWord, expQ.size() > 0 ? expQ.pop_front() : 'x);

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    @(posedge clk);
    #1 chk({120'h0, regRdData}, {120'h0, e});
  endtask

  // enable, fill, pin and channel-one priority
  function automatic logic [63:0] pinExp(input logic p, input logic [4:0] pos);
    logic [63:0] v;
    v = fill ? 64'h0 : {32'h0, 32'hffffffff};
    if (cfg2[5] && sel[1] == p && cfg2[4:0] == pos) v = {s2, 32'hffffffff};
    if (cfg1[5] && sel[0] == p && cfg1[4:0] == pos) v = {s1, 32'hffffffff};
    return v;
  endfunction

  // Reserved upper bits are only ever written as zero; they must read back zero
  task automatic setup(input logic [7:0] c1, input logic [7:0] c2, input logic f,
      input logic fl, input logic [1:0] sl);
    cfg1 = c1;
    cfg2 = c2;
    wr(ADDR_CH1_CFG, {2'b00, c1[5:0]});
    rd(ADDR_CH1_CFG, c1);
    wr(ADDR_CH2_CFG, {2'b00, c2[5:0]});
    rd(ADDR_CH2_CFG, c2);
    fmt <= f;
    fill <= fl;
    sel <= sl;
    s1 <= $random(seed);
    s2 <= $random(seed);
    sampleValid <= 1'b1;
    @(posedge clk);
    sampleValid <= 1'b0;
  endtask

  task automatic frame(input logic f, input int n, input string name);
    logic [4:0] pos;
    for (int k = 0; k < n; k++)
    begin
      pos = f ? 5'((k / (n / 2)) * 16 + k % (n / 2)) : 5'(k);
      expQ.push_back({pinExp(1'b0, pos), pinExp(1'b1, pos)});
    end
    u_atsm_host_port.runFrame(f, n);
    for (int w = 0; w < 2000 && expQ.size() > 0; w++) @(posedge clk);
    $display("test %s done", name);
  endtask

  task automatic finishTest;
    $display("checks %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CH1_CFG, RST_CH1_CFG);
    rd(ADDR_CH2_CFG, RST_CH2_CFG);
    rd(8'h40, 8'h00);
    setup(RST_CH1_CFG, RST_CH2_CFG, FMT_TDM, 1'b1, 2'b00);
    frame(FMT_TDM, 4, "reset map");
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      setup({2'b00, r[0], i[0] ? {r[4], 3'b000, r[1]} : {3'b000, r[2:1]}},
        {2'b00, r[8], i[0] ? {r[9], 3'b000, r[10]} : {3'b000, r[10:9]}}, i[0], r[5], r[7:6]);
      frame(i[0], 4, "random map");
    end
    setup(8'h3f, 8'h30, FMT_TDM, 1'b0, 2'b10);
    frame(FMT_TDM, 32, "tdm edge slots");
    setup(8'h2f, 8'h3f, FMT_I2S_LJ, 1'b1, 2'b00);
    frame(FMT_I2S_LJ, 32, "half edge slots");
    setup(8'h22, 8'h22, FMT_TDM, 1'b1, 2'b11);
    frame(FMT_TDM, 4, "slot clash");
    finishTest;
  end

  initial
  begin
    repeat (90000) @(posedge clk);
    badCount++;
    $display("watchdog expired");
    finishTest;
  end
endmodule // test_atsm_tx_slot_map
`default_nettype wire
